// *** hw/autoneg_partner_defines.vh ***
`ifndef AUTONEG_PARTNER_DEFINES_VH
`define AUTONEG_PARTNER_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_PARTNER_ABILITY   4'h5
`define IDX_EXPANSION         4'h6
`define IDX_NEXT_PAGE_TX      4'h7
`define IDX_AN_CONTROL        4'h8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PARTNER_ABILITY   16'h0000
`define RST_EXPANSION         16'h0004
`define RST_NEXT_PAGE_TX      16'h2001
`define RST_NULL_CODE         11'h001

// ----------------------------------------
// Partner ability fields
// ----------------------------------------
`define PA_NEXT_PAGE          15
`define PA_ACK                14
`define PA_REMOTE_FAULT       13
`define PA_RSVD               12
`define PA_ASYM_PAUSE         11
`define PA_PAUSE              10
`define PA_T4                 9
`define PA_TX_FD              8
`define PA_TX_HD              7
`define PA_10_FD              6
`define PA_10_HD              5
`define PA_SEL_HI             4
`define PA_SEL_LO             0

// ----------------------------------------
// Expansion fields
// ----------------------------------------
`define EX_PD_FAULT           4
`define EX_LP_NP_ABLE         3
`define EX_LOCAL_NP_ABLE      2
`define EX_PAGE_RX            1
`define EX_LP_AN_ABLE         0
`define EX_RSVD_W             11

// ----------------------------------------
// Next page transmit fields
// ----------------------------------------
`define NP_NEXT_PAGE          15
`define NP_MSG_PAGE           13
`define NP_ACK2               12
`define NP_TOGGLE             11
`define NP_CODE_HI            10
`define NP_CODE_LO            0
`define NP_WR_MASK            16'hb7ff

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define ADR_IDX_HI            5
`define ADR_IDX_LO            2
`define REG_W                 16
`define BYTE_W                8
`define NUM_LANES             2
`define CTL_LANE              0
`define CTL_RESTART           0
`define UPPER_ZERO            16'h0000
`define RDATA_ZERO            32'h0000_0000

`endif

// *** hw/autoneg_partner_status_regs.v ***
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps

// Functional notes
// - Bit 15: partner requests next page
// - Bit 14: partner acknowledges our code word
// - Bit 13: partner advertises remote fault
// - Bit 11: partner asymmetric pause
// - Bit 10: partner symmetric pause
// - Bit 9: partner 100Base-T4
// - Bits 8,7: partner 100TX full/half
// - Bits 6,5: partner 10T full/half
// - Bits 4:0: partner selector field
// - Ability at 0x5, reset 0, read-only
// - Expansion at 0x6, reset 0x4, upper zero
// - Bit 4: parallel detection fault flag
// - Bit 3: partner next page able
// - Bit 2: local next page able, 1
// - Bit 1: new page received flag
// - Bit 0: partner auto-negotiation able
// - Next page transmit at 0x7, reset 0x2001
// - Reset code field is null message
module autoneg_partner_status_regs (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  output wire        err_o,
  // Arbitration side (same clock)
  input  wire [15:0] rx_base_page_i,
  input  wire        base_page_accept_i,
  input  wire        page_rx_i,
  input  wire        pd_fault_i,
  input  wire        lp_an_able_i,
  input  wire        toggle_i,
  input  wire        np_sent_i,
  output reg  [15:0] np_word_o,
  output reg         an_restart_o
);

`include "autoneg_partner_defines.vh"

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  reg         ack_r;
  reg         ack_nxt;
  reg         err_r;
  reg         err_nxt;
  wire        req;
  wire        hit;
  wire [3:0]  idx;
  wire        is_ability;
  wire        is_exp;
  wire        is_np;
  wire        is_ctl;
  wire        rd_req;
  wire        rd_exp;
  wire        wr;

  assign idx        = adr_i[`ADR_IDX_HI:`ADR_IDX_LO];
  assign is_ability = (idx == `IDX_PARTNER_ABILITY);
  assign is_exp     = (idx == `IDX_EXPANSION);
  assign is_np      = (idx == `IDX_NEXT_PAGE_TX);
  assign is_ctl     = (idx == `IDX_AN_CONTROL);
  assign hit        = is_ability | is_exp | is_np | is_ctl;

  // A pending answer blocks a second take of the same request
  assign req    = cyc_i & stb_i & ~ack_r & ~err_r;
  assign rd_req = req & ~we_i;
  // Read of the expansion word clears the latched flags
  assign rd_exp = rd_req & is_exp;

  // Writes land on the edge at which the master sees ack
  assign wr     = cyc_i & stb_i & we_i & ack_r;

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  assign ack_o = ack_r;
  assign err_o = err_r;

  always @* begin
    ack_nxt = req & hit;
  end

  always @* begin
    err_nxt = req & ~hit;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------
  // Partner ability register
  // ----------------------------------------
  reg  [15:0] ability_r;
  reg  [15:0] ability_nxt;

  always @* begin
    ability_nxt = ability_r;
    if (base_page_accept_i) begin
      ability_nxt = rx_base_page_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ability_r <= `RST_PARTNER_ABILITY;
    end else begin
      ability_r <= ability_nxt;
    end
  end

  // ----------------------------------------
  // Partner ability fields
  // ----------------------------------------
  wire        lp_np_req;
  wire        lp_ack;
  wire        lp_rfault;
  wire        lp_asym_pause;
  wire        lp_pause;
  wire        lp_t4;
  wire        lp_tx_fd;
  wire        lp_tx_hd;
  wire        lp_10_fd;
  wire        lp_10_hd;
  wire [4:0]  lp_selector;
  wire [15:0] ability_view;

  assign lp_np_req     = ability_r[`PA_NEXT_PAGE];
  assign lp_ack        = ability_r[`PA_ACK];
  assign lp_rfault     = ability_r[`PA_REMOTE_FAULT];
  assign lp_asym_pause = ability_r[`PA_ASYM_PAUSE];
  assign lp_pause      = ability_r[`PA_PAUSE];
  assign lp_t4         = ability_r[`PA_T4];
  assign lp_tx_fd      = ability_r[`PA_TX_FD];
  assign lp_tx_hd      = ability_r[`PA_TX_HD];
  assign lp_10_fd      = ability_r[`PA_10_FD];
  assign lp_10_hd      = ability_r[`PA_10_HD];
  assign lp_selector   = ability_r[`PA_SEL_HI:`PA_SEL_LO];

  // Bit 12 is reserved and reads zero whatever the partner sent
  assign ability_view = {lp_np_req,
                         lp_ack,
                         lp_rfault,
                         1'b0,
                         lp_asym_pause,
                         lp_pause,
                         lp_t4,
                         lp_tx_fd,
                         lp_tx_hd,
                         lp_10_fd,
                         lp_10_hd,
                         lp_selector};

  // ----------------------------------------
  // Expansion flags
  // ----------------------------------------
  reg         pd_fault_r;
  reg         pd_fault_nxt;
  reg         page_rx_r;
  reg         page_rx_nxt;
  reg         lp_an_able_r;
  reg         lp_an_able_nxt;

  // Set wins over clear-on-read
  always @* begin
    pd_fault_nxt = pd_fault_i | (pd_fault_r & ~rd_exp);
  end

  always @* begin
    page_rx_nxt = page_rx_i | (page_rx_r & ~rd_exp);
  end

  always @* begin
    lp_an_able_nxt = lp_an_able_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pd_fault_r <= 1'b0;
    end else begin
      pd_fault_r <= pd_fault_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      page_rx_r <= 1'b0;
    end else begin
      page_rx_r <= page_rx_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lp_an_able_r <= 1'b0;
    end else begin
      lp_an_able_r <= lp_an_able_nxt;
    end
  end

  // ----------------------------------------
  // Expansion view
  // ----------------------------------------
  wire [10:0] exp_rsvd;
  wire        lp_np_able;
  wire        local_np_able;
  wire [15:0] exp_view;

  assign exp_rsvd      = {`EX_RSVD_W{1'b0}};
  assign lp_np_able    = lp_np_req;
  assign local_np_able = 1'b1;

  assign exp_view = {exp_rsvd,
                     pd_fault_r,
                     lp_np_able,
                     local_np_able,
                     page_rx_r,
                     lp_an_able_r};

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  wire [15:0] lane_en;
  wire [15:0] wmask;
  genvar      g;

  generate
    for (g = 0; g < `NUM_LANES; g = g + 1) begin : g_lane
      assign lane_en[g*`BYTE_W +: `BYTE_W] = {`BYTE_W{sel_i[g]}};
    end
  endgenerate

  // Reserved bit and toggle bit never take bus data
  assign wmask = lane_en & `NP_WR_MASK;

  // ----------------------------------------
  // Next page transmit register
  // ----------------------------------------
  reg  [15:0] np_r;
  reg  [15:0] np_nxt;
  reg         toggle_r;
  reg         toggle_nxt;

  always @* begin
    np_nxt = np_r;
    if (wr & is_np) begin
      np_nxt = (np_r & ~wmask) | (dat_i[`REG_W-1:0] & wmask);
    end
  end

  always @* begin
    toggle_nxt = toggle_r;
    if (np_sent_i) begin
      toggle_nxt = toggle_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      np_r <= `RST_NEXT_PAGE_TX;
    end else begin
      np_r <= np_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      toggle_r <= 1'b0;
    end else begin
      toggle_r <= toggle_nxt;
    end
  end

  // ----------------------------------------
  // Next page fields
  // ----------------------------------------
  wire [3:0]  np_flags;
  wire [10:0] np_code;
  wire [15:0] np_view;

  assign np_flags = np_r[`NP_NEXT_PAGE:`NP_ACK2];
  assign np_code  = np_r[`NP_CODE_HI:`NP_CODE_LO];

  // Toggle bit comes from arbitration, not from the stored word
  assign np_view = {np_flags, toggle_r, np_code};

  // ----------------------------------------
  // Next page word toward arbitration
  // ----------------------------------------
  reg  [15:0] np_word_nxt;

  always @* begin
    np_word_nxt = np_view;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      np_word_o <= `RST_NEXT_PAGE_TX;
    end else begin
      np_word_o <= np_word_nxt;
    end
  end

  // ----------------------------------------
  // Restart pulse
  // ----------------------------------------
  reg         restart_nxt;

  always @* begin
    restart_nxt = wr & is_ctl & sel_i[`CTL_LANE] & dat_i[`CTL_RESTART];
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      an_restart_o <= 1'b0;
    end else begin
      an_restart_o <= restart_nxt;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg  [31:0] rdata_nxt;

  always @* begin
    rdata_nxt = dat_o;
    if (rd_req) begin
      case (idx)
        `IDX_PARTNER_ABILITY: begin
          rdata_nxt = {`UPPER_ZERO, ability_view};
        end
        `IDX_EXPANSION: begin
          rdata_nxt = {`UPPER_ZERO, exp_view};
        end
        `IDX_NEXT_PAGE_TX: begin
          rdata_nxt = {`UPPER_ZERO, np_view};
        end
        default: begin
          rdata_nxt = `RDATA_ZERO;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `RDATA_ZERO;
    end else begin
      dat_o <= rdata_nxt;
    end
  end

endmodule

// *** testbench/an_regs_sva.sv ***
`timescale 1ns/100ps
module an_regs_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [5:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        err_o,
  input wire        toggle_i,
  input wire        np_sent_i,
  input wire [15:0] np_word_o
);
  wire rd_w = ack_o && !we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held too long");
  chk_one_answer: assert property (
    cyc_i && stb_i && !ack_o && !err_o |=> ack_o != err_o)
    else $error("no single answer");
  chk_upper_half: assert property (
    rd_w |-> dat_o[31:16] == 16'h0)
    else $error("upper half not zero");
  chk_ab_rsvd: assert property (
    rd_w && adr_i[5:2] == 4'h5 |-> !dat_o[12])
    else $error("ability bit 12 set");
  chk_exp_fixed: assert property (
    rd_w && adr_i[5:2] == 4'h6 |-> dat_o[15:5] == 11'h0 && dat_o[2])
    else $error("expansion fixed bits");
  chk_np_reset: assert property (
    $fell(rst_i) |-> np_word_o == 16'h2001)
    else $error("next page reset value");
  chk_np_rsvd: assert property (
    !np_word_o[14])
    else $error("next page bit 14 set");
  chk_np_toggle: assert property (
    np_sent_i |=> ##1 np_word_o[11] == $past(toggle_i, 2))
    else $error("toggle not latched");
endmodule
bind autoneg_partner_status_regs an_regs_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .toggle_i(toggle_i), .np_sent_i(np_sent_i), .np_word_o(np_word_o));

// *** testbench/link_partner_model.sv ***
`timescale 1ns/100ps
module link_partner_model (
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [15:0] page_i,
  input  wire [3:0]  dly_i,
  output reg  [15:0] page_o = 16'h0,
  output reg         accept_o = 1'b0,
  output reg         rx_o = 1'b0
);
  reg [15:0] held_r = 16'h0;
  reg [4:0]  cnt_r  = 5'h0;
  always @(posedge clk_i) begin
    accept_o <= 1'b0;
    rx_o     <= 1'b0;
    // Word is noise outside the accept cycle
    page_o   <= ~page_o;
    if (go_i) begin
      held_r <= page_i;
      cnt_r  <= {1'b0, dly_i} + 5'h1;
    end else if (cnt_r != 5'h0) begin
      cnt_r <= cnt_r - 5'h1;
      if (cnt_r == 5'h1) begin
        page_o   <= held_r;
        accept_o <= 1'b1;
        rx_o     <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/autoneg_partner_status_regs_tb.sv ***
`timescale 1ns/100ps
module autoneg_partner_status_regs_tb;
  reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  reg         pd = 0, lp = 0, tog = 0, nps = 0, go = 0;
  reg  [5:0]  adr_i = 0;
  reg  [31:0] dat_i = 0, s, r, q;
  reg  [15:0] pg = 0, ab;
  reg  [3:0]  dl = 0;
  reg         e;
  wire [31:0] dat_o;
  wire [15:0] rxp, npw;
  wire        ack_o, err_o, acc, prx;
  integer     n_errors = 0, compares = 0, i, n;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  link_partner_model i_lp (.clk_i(clk_i), .go_i(go), .page_i(pg), .dly_i(dl),
    .page_o(rxp), .accept_o(acc), .rx_o(prx));
  autoneg_partner_status_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .rx_base_page_i(rxp),
    .base_page_accept_i(acc), .page_rx_i(prx), .pd_fault_i(pd), .lp_an_able_i(lp),
    .toggle_i(tog), .np_sent_i(nps), .np_word_o(npw), .an_restart_o());
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  task report_and_stop;
    begin
      if (n_errors == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wb(input w, input [3:0] ix, input [31:0] d);
    begin
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, ix, 2'b00, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 8) begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = dat_o;
      e = err_o;
      {cyc_i, stb_i} <= 2'b00;
      @(posedge clk_i);
      if (n == 8) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask
  task rd(input [3:0] ix, input [31:0] exp);
    begin
      wb(1'b0, ix, 32'h0);
      chk("read", q, exp);
      chk("read err", e, 1'b0);
    end
  endtask
  initial begin
    s = 32'h76d7dc41;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h5, 32'h0);
    rd(4'h6, 32'h4);
    rd(4'h7, 32'h2001);
    chk("np word", npw, 32'h2001);
    wb(1'b0, 4'h2, 32'h0);
    chk("err", e, 1'b1);
    for (i = 0; i < 16; i = i + 1) begin
      s = xs(s);
      r = s;
      {dl, pd, lp, pg, go} <= {r[21:16], r[15:0], 1'b1};
      ab = r[15:0] & 16'hefff;
      @(posedge clk_i);
      {go, pd} <= 2'b00;
      n = 0;
      while (acc !== 1'b1 && n < 20) begin
        @(posedge clk_i);
        n = n + 1;
      end
      chk("accept", n < 20, 1'b1);
      if (n == 20) begin
        report_and_stop;
      end
      repeat (2) @(posedge clk_i);
      rd(4'h5, {16'h0, ab});
      chk("ab hi", q[15:13], ab[15:13]);
      chk("ab pause", q[11:10], ab[11:10]);
      chk("ab tech", q[9:5], ab[9:5]);
      rd(4'h6, {27'h0, r[17], ab[15], 2'b11, r[16]});
      chk("exp partner", {q[3], q[0]}, {ab[15], r[16]});
      rd(4'h6, {27'h0, 1'b0, ab[15], 2'b10, r[16]});
      wb(1'b1, 4'h5, ~r);
      rd(4'h5, {16'h0, ab});
      {tog, nps} <= {r[24], 1'b1};
      @(posedge clk_i);
      nps <= 1'b0;
      wb(1'b1, 4'h7, r);
      rd(4'h7, (r & 32'hb7ff) | {r[24], 11'h0});
      chk("np word", npw, (r & 32'hb7ff) | {r[24], 11'h0});
    end
    report_and_stop;
  end
endmodule
